// ### rtl/rms_defines.vh
`ifndef RMS_ENGINE_DEFINES_VH
`define RMS_ENGINE_DEFINES_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_MODE_CONTROL_TWO 8'h0C
`define IDX_WAVEFORM_SOURCE_SELECT 8'h0D
`define IDX_MEAS_IRQ_ENABLE_HIGH 8'hDB
`define IDX_CURRENT_RMS_RESULT 8'hE0
`define IDX_CURRENT_RMS_OFFSET 8'hE1
`define IDX_VOLTAGE_RMS_RESULT 8'hE2
`define IDX_VOLTAGE_RMS_OFFSET 8'hE3

// ==========================================================
// Field positions
`define BIT_RMS_ZERO_CROSS_UPDATE 3
`define BIT_WAVEFORM_SAMPLE_IRQ_ENABLE 0
`define WSEL_SOURCE_HI 2
`define WSEL_SOURCE_LO 0
`define WSEL_RATE_HI 4
`define WSEL_RATE_LO 3
`define WSRC_CURRENT_RMS 3'h5

// ==========================================================
// Reset values
`define RST_BYTE 8'h00
`define RST_OFFSET 12'h000
`define RST_RESULT 24'h000000

// ==========================================================
// Timing and scaling
`define UPDATE_DIV_LAST 3'h4
`define WAVE_DIV_BASE 11'h0A0
`define LPF_SHIFT 16
`define CUR_OFFSET_SHIFT 15
`define VOLT_OFFSET_SHIFT 6
`define VOLT_SAMPLE_SHIFT 8
`define WAVE_RMS_GAIN 5'h16
`define ROOT_DIGITS_PER_STEP 5
`define ROOT_LAST_STEP 3'h4
`define RESULT_MAX 24'hFFFFFF
`define MS_MAX 48'hFFFFFFFFFFFF

`endif

// ### rtl/rms_measurement_engine.v
`timescale 1ns/1ps
// Summary of operation
// - Square samples, average in 2 Hz low-pass, then take square root.
// - Current and voltage rms run together, each in its own register.
// - Current rms goes to waveform output when selected and enabled.
// - Waveform current rms sample wraps above about 40 percent scale.
// - Current rms is unsigned 24-bit, LSB equal to a sample LSB.
// - Current rms updates every fifth clock unless zero-cross mode.
// - Zero-cross mode bit refreshes both results on voltage crossings.
// - Full-scale current gives about 0x172BA3 or 0x1CF68C by gain.
// - Current offset adds offset times 32768 to square before root.
// - Voltage rms unsigned 24-bit, updated every fifth clock unless zero-cross mode.
// - Full-scale voltage swing 0x28F5 peak gives about 0x1CF68C.
// - Voltage offset adds 64 times signed offset after the root.
module rms_measurement_engine (
	input wire mclk, // system clock
	input wire rst, // async reset, active high
	input wire ce, // clock enable, freezes all state
	input wire [23:0] current_sample, // signed current waveform sample
	input wire [15:0] voltage_sample, // signed filtered voltage sample
	input wire voltage_zero_cross, // pulse on voltage zero crossing
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error on unmapped access
	output reg [23:0] wave_data_r, // waveform sample
	output reg wave_strobe_r // waveform sample strobe
);
`include "rms_defines.vh"

// ==========================================================
// Register state
reg [7:0] mode_control_two_r;
reg [7:0] waveform_source_select_r;
reg [7:0] measurement_irq_enable_high_r;
reg [11:0] current_rms_offset_r;
reg [11:0] voltage_rms_offset_r;
reg [23:0] current_rms_result_r;
reg [23:0] voltage_rms_result_r;
reg [23:0] current_rms_raw_r;
reg [23:0] voltage_rms_raw_r;
reg [2:0] update_div_r;
reg update_tick_r;
reg [10:0] wave_div_r;

wire rms_zero_cross_update;
wire waveform_sample_irq_enable;
wire [2:0] wave_source;
wire [1:0] wave_rate;
wire [10:0] wave_div_last;
wire [23:0] chan_x [0:1];
wire [47:0] chan_ms [0:1];
wire [47:0] chan_rad [0:1];
wire [23:0] chan_root [0:1];
wire chan_done [0:1];
wire [7:0] reg_index;
wire addr_aligned;

assign rms_zero_cross_update =
	mode_control_two_r[`BIT_RMS_ZERO_CROSS_UPDATE];
assign waveform_sample_irq_enable =
	measurement_irq_enable_high_r[`BIT_WAVEFORM_SAMPLE_IRQ_ENABLE];
assign wave_source =
	waveform_source_select_r[`WSEL_SOURCE_HI:`WSEL_SOURCE_LO];
assign wave_rate = waveform_source_select_r[`WSEL_RATE_HI:`WSEL_RATE_LO];
assign reg_index = paddr[9:2];
assign addr_aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);

// ==========================================================
// Functions

// Reads a mapped register; flags unmapped indices
function [32:0] read_reg;
	input [7:0] idx;
	begin
		if (idx == `IDX_MODE_CONTROL_TWO)
			read_reg = {1'b1, 24'h0, mode_control_two_r};
		else if (idx == `IDX_WAVEFORM_SOURCE_SELECT)
			read_reg = {1'b1, 24'h0, waveform_source_select_r};
		else if (idx == `IDX_MEAS_IRQ_ENABLE_HIGH)
			read_reg = {1'b1, 24'h0, measurement_irq_enable_high_r};
		else if (idx == `IDX_CURRENT_RMS_RESULT)
			read_reg = {1'b1, 8'h0, current_rms_result_r};
		else if (idx == `IDX_CURRENT_RMS_OFFSET)
			read_reg = {1'b1, 20'h0, current_rms_offset_r};
		else if (idx == `IDX_VOLTAGE_RMS_RESULT)
			read_reg = {1'b1, 8'h0, voltage_rms_result_r};
		else if (idx == `IDX_VOLTAGE_RMS_OFFSET)
			read_reg = {1'b1, 20'h0, voltage_rms_offset_r};
		else
			read_reg = 33'h0;
	end
endfunction

// True when a write to this index is mapped and writable
function is_writable;
	input [7:0] idx;
	begin
		is_writable = (idx == `IDX_MODE_CONTROL_TWO) ||
			(idx == `IDX_WAVEFORM_SOURCE_SELECT) ||
			(idx == `IDX_MEAS_IRQ_ENABLE_HIGH) ||
			(idx == `IDX_CURRENT_RMS_OFFSET) ||
			(idx == `IDX_VOLTAGE_RMS_OFFSET);
	end
endfunction

// Clamps a corrected voltage root into the 24-bit result range; a
// negative offset on a quiet channel must read zero, not wrap high
function [23:0] clamp_result;
	input [25:0] val;
	begin
		if (val[25])
			clamp_result = `RST_RESULT;
		else if (val[24])
			clamp_result = `RESULT_MAX;
		else
			clamp_result = val[23:0];
	end
endfunction

// Refusal decode from the setup-phase address and direction
wire [32:0] read_word;
wire access_refused;
assign read_word = read_reg(reg_index);
assign access_refused = !addr_aligned ||
	(pwrite ? !is_writable(reg_index) : !read_word[32]);

// ==========================================================
// APB slave, zero wait states; answer prepared in setup phase
always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		prdata <= 32'h0;
		pready <= 1'b0;
		pslverr <= 1'b0;
		mode_control_two_r <= `RST_BYTE;
		waveform_source_select_r <= `RST_BYTE;
		measurement_irq_enable_high_r <= `RST_BYTE;
		current_rms_offset_r <= `RST_OFFSET;
		voltage_rms_offset_r <= `RST_OFFSET;
	end
	else if (ce)
	begin
		pready <= psel && !penable;
		pslverr <= 1'b0; // Error stands with ready only
		if (psel && !penable)
		begin
			// Read-only results refuse writes with an error
			prdata <= pwrite ? 32'h0 : read_word[31:0];
			pslverr <= access_refused;
		end
		if (psel && penable && pready && pwrite && !pslverr)
		begin
			if (reg_index == `IDX_MODE_CONTROL_TWO)
				mode_control_two_r <= pwdata[7:0];
			else if (reg_index == `IDX_WAVEFORM_SOURCE_SELECT)
				waveform_source_select_r <= pwdata[7:0];
			else if (reg_index == `IDX_MEAS_IRQ_ENABLE_HIGH)
				measurement_irq_enable_high_r <= pwdata[7:0];
			else if (reg_index == `IDX_CURRENT_RMS_OFFSET)
				current_rms_offset_r <= pwdata[11:0];
			else if (reg_index == `IDX_VOLTAGE_RMS_OFFSET)
				voltage_rms_offset_r <= pwdata[11:0];
		end
	end
end

// ==========================================================
// Update tick at one fifth of the clock
// One tick serves both channels, so the two results stay in step
always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		update_div_r <= 3'h0;
		update_tick_r <= 1'b0;
	end
	else if (ce)
	begin
		update_tick_r <= (update_div_r == `UPDATE_DIV_LAST);
		if (update_div_r == `UPDATE_DIV_LAST)
			update_div_r <= 3'h0;
		else
			update_div_r <= update_div_r + 3'h1;
	end
end

// ==========================================================
// Channel inputs; voltage scaled so 0x28F5 peak lands near 0x1CF68C
// Voltage path has 16 bits; shifting by eight puts both on one scale
assign chan_x[0] = current_sample;
assign chan_x[1] = {voltage_sample, 8'h00};

// ==========================================================
// Per-channel square, average and root, both channels in parallel
genvar ch;
generate
	for (ch = 0; ch < 2; ch = ch + 1)
	begin : g_chan
		reg [63:0] lpf_acc_r;
		wire [23:0] mag;
		wire [47:0] square;

		assign mag = chan_x[ch][23] ? (~chan_x[ch] + 24'h1) : chan_x[ch];
		assign square = mag * mag;

		// First-order average: corner near 2 Hz at 4.096 MHz / 5
		// The slow corner means a fresh input needs hundreds of
		// thousands of clocks to settle; reads before that see a
		// partial average, not a wrong one
		always @(posedge mclk or posedge rst)
		begin
			if (rst)
				lpf_acc_r <= 64'h0;
			else if (ce && update_tick_r)
				lpf_acc_r <= lpf_acc_r - {16'h0, lpf_acc_r[63:`LPF_SHIFT]} +
					{16'h0, square};
		end
		assign chan_ms[ch] = lpf_acc_r[63:`LPF_SHIFT];

		// Root restarts on every tick; five digits a cycle finish it
		// just before the next tick, so no average is ever skipped
		rms_root_unit u_root (
			.mclk(mclk),
			.rst(rst),
			.ce(ce),
			.start(update_tick_r),
			.radicand(chan_rad[ch]),
			.root(chan_root[ch]),
			.done(chan_done[ch])
		);
	end
endgenerate

// ==========================================================
// Current offset acts on the square, clamped to the 48-bit range
// Weight 32768 per offset step follows the correction equation;
// a quiet channel then reads the square root of the offset term
wire signed [50:0] cur_ms_corr;
assign cur_ms_corr = $signed({3'b000, chan_ms[0]}) +
	($signed({{39{current_rms_offset_r[11]}}, current_rms_offset_r})
	<<< `CUR_OFFSET_SHIFT);
assign chan_rad[0] = cur_ms_corr[50] ? 48'h0 :
	(|cur_ms_corr[49:48]) ? `MS_MAX : cur_ms_corr[47:0];
assign chan_rad[1] = chan_ms[1];

// ==========================================================
// Voltage offset acts linearly on the root, clamped to 24 bits
// Unlike the current offset it is linear, so it can push below zero
wire signed [25:0] volt_corr;
assign volt_corr = $signed({2'b00, chan_root[1]}) +
	($signed({{14{voltage_rms_offset_r[11]}}, voltage_rms_offset_r})
	<<< `VOLT_OFFSET_SHIFT);

// ==========================================================
// Latest roots, then publish per tick or on voltage zero crossing
// Held roots keep running in zero-cross mode for the next crossing
always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		current_rms_raw_r <= `RST_RESULT;
		voltage_rms_raw_r <= `RST_RESULT;
	end
	else if (ce)
	begin
		if (chan_done[0])
			current_rms_raw_r <= chan_root[0];
		if (chan_done[1])
			voltage_rms_raw_r <= clamp_result(volt_corr);
	end
end

// Zero-cross mode copies the newest held value, so a crossing that
// lands between roots still publishes a fresh average
// A crossing pulse in normal mode is ignored
always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		current_rms_result_r <= `RST_RESULT;
		voltage_rms_result_r <= `RST_RESULT;
	end
	else if (ce)
	begin
		if (rms_zero_cross_update)
		begin
			if (voltage_zero_cross)
			begin
				current_rms_result_r <= current_rms_raw_r;
				voltage_rms_result_r <= voltage_rms_raw_r;
			end
		end
		else
		begin
			if (chan_done[0])
				current_rms_result_r <= chan_root[0];
			if (chan_done[1])
				voltage_rms_result_r <= clamp_result(volt_corr);
		end
	end
end

// ==========================================================
// Waveform path: rate divider 160, 320, 640 or 1280 clocks
assign wave_div_last = (`WAVE_DIV_BASE << wave_rate) - 11'h1;

// Scaled sample runs past 24 bits near 40 percent and wraps
// Only the low 24 bits leave; software must keep inputs below that
wire [28:0] wave_scaled;
assign wave_scaled = current_rms_raw_r * `WAVE_RMS_GAIN;

always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		wave_div_r <= 11'h0;
		wave_data_r <= `RST_RESULT;
		wave_strobe_r <= 1'b0;
	end
	else if (ce)
	begin
		wave_strobe_r <= 1'b0;
		if (!(waveform_sample_irq_enable &&
			wave_source == `WSRC_CURRENT_RMS))
			wave_div_r <= 11'h0;
		else if (wave_div_r >= wave_div_last)
		begin
			wave_div_r <= 11'h0;
			wave_data_r <= wave_scaled[23:0];
			wave_strobe_r <= 1'b1;
		end
		else
			wave_div_r <= wave_div_r + 11'h1;
	end
end

endmodule // rms_measurement_engine

// ### rtl/rms_root_unit.v
`timescale 1ns/1ps
// Square root of a 48-bit mean square, five result digits per cycle,
// so a new root is ready exactly five cycles after start.
module rms_root_unit (
	input wire mclk, // system clock
	input wire rst, // async reset, active high
	input wire ce, // clock enable
	input wire start, // one-cycle start pulse
	input wire [47:0] radicand, // value to root
	output reg [23:0] root, // finished root
	output reg done // one-cycle done pulse
);
`include "rms_defines.vh"

reg [49:0] rad_r;
reg [27:0] rem_r;
reg [24:0] acc_r;
reg [2:0] step_r;
reg busy_r;
reg [49:0] rad_nxt;
reg [27:0] rem_nxt;
reg [24:0] acc_nxt;
reg [27:0] trial;
integer i;

// ==========================================================
// Digit recurrence
// Start restarts from scratch even while busy, so back-to-back works
always @*
begin
	rad_nxt = start ? {2'b00, radicand} : rad_r;
	rem_nxt = start ? 28'h0 : rem_r;
	acc_nxt = start ? 25'h0 : acc_r;
	trial = 28'h0;
	for (i = 0; i < `ROOT_DIGITS_PER_STEP; i = i + 1)
	begin
		rem_nxt = {rem_nxt[25:0], rad_nxt[49:48]};
		rad_nxt = {rad_nxt[47:0], 2'b00};
		trial = {1'b0, acc_nxt, 2'b01};
		if (rem_nxt >= trial)
		begin
			rem_nxt = rem_nxt - trial;
			acc_nxt = {acc_nxt[23:0], 1'b1};
		end
		else
			acc_nxt = {acc_nxt[23:0], 1'b0};
	end
end

// ==========================================================
// Step sequencing
always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		rad_r <= 50'h0;
		rem_r <= 28'h0;
		acc_r <= 25'h0;
		step_r <= 3'h0;
		busy_r <= 1'b0;
		root <= 24'h0;
		done <= 1'b0;
	end
	else if (ce)
	begin
		done <= 1'b0;
		if (start || busy_r)
		begin
			rad_r <= rad_nxt;
			rem_r <= rem_nxt;
			acc_r <= acc_nxt;
			step_r <= start ? 3'h1 : step_r + 3'h1;
			busy_r <= 1'b1;
			if (!start && step_r == `ROOT_LAST_STEP)
			begin
				busy_r <= 1'b0;
				done <= 1'b1;
				root <= acc_nxt[23:0]; // Root of 48 bits fits 24
			end
		end
	end
end

endmodule // rms_root_unit

// ### tb/rms_engine_props.sv
`timescale 1ns/1ps
`include "rms_defines.vh"
// ==========================================================
// Port checker
module rms_engine_props (
	input wire mclk, // system clock
	input wire rst, // async reset
	input wire psel, // bus select
	input wire penable, // bus enable
	input wire pwrite, // bus direction
	input wire [11:0] paddr, // bus address
	input wire [31:0] prdata, // read data
	input wire pready, // ready
	input wire pslverr, // error
	input wire [23:0] wave_data_r, // waveform sample
	input wire wave_strobe_r // waveform strobe
);
	// One clock domain only
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	a_zero_wait: assert property (psel && !penable |=> pready)
		else $error("no answer in first access cycle");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready held past one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_cur_ro: assert property (psel && !penable && pwrite &&
		paddr[9:2] == `IDX_CURRENT_RMS_RESULT |=> pslverr)
		else $error("current result write not refused");
	a_volt_ro: assert property (psel && !penable && pwrite &&
		paddr[9:2] == `IDX_VOLTAGE_RMS_RESULT |=> pslverr)
		else $error("voltage result write not refused");
	a_result_width: assert property (pready && !pwrite && !pslverr &&
		paddr[9:2] == `IDX_CURRENT_RMS_RESULT |-> prdata[31:24] == 8'h00)
		else $error("result wider than 24 bits");
	a_strobe_gap: assert property (wave_strobe_r |=> !wave_strobe_r [*8])
		else $error("waveform strobes too close");
	a_wave_hold: assert property (!wave_strobe_r |-> $stable(wave_data_r))
		else $error("waveform data moved without strobe");
endmodule // rms_engine_props

bind rms_measurement_engine rms_engine_props rms_engine_props_i (
	.mclk(mclk),
	.rst(rst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.wave_data_r(wave_data_r),
	.wave_strobe_r(wave_strobe_r)
);

// ### tb/sample_source.sv
`timescale 1ns/1ps
// ==========================================================
// Channel sample paths
module sample_source (
	input wire mclk, // system clock
	input wire rst, // async reset
	input wire zx_req, // ask for one crossing
	input wire [23:0] cur_level, // current level to drive
	input wire [15:0] volt_level, // voltage level to drive
	output reg [23:0] current_sample, // current channel sample
	output reg [15:0] voltage_sample, // voltage channel sample
	output reg voltage_zero_cross // crossing pulse
);
	// Channels follow the asked levels; quiet levels keep sums exact
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			current_sample <= 24'h000000;
			voltage_sample <= 16'h0000;
			voltage_zero_cross <= 1'b0;
		end
		else
		begin
			current_sample <= cur_level;
			voltage_sample <= volt_level;
			voltage_zero_cross <= zx_req;
		end
	end
endmodule // sample_source

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "rms_defines.vh"
module tb_top;
	reg mclk = 1'b0;
	reg rst = 1'b1;
	reg ce = 1'b1;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg zx_req = 1'b0;
	reg [23:0] cur_level = 24'h000000;
	reg [15:0] volt_level = 16'h0000;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h00000000;
	reg [31:0] rd;
	reg er;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire [23:0] wave_data_r;
	wire wave_strobe_r;
	wire [23:0] current_sample;
	wire [15:0] voltage_sample;
	wire voltage_zero_cross;
	integer errors = 0;
	integer checks = 0;
	integer cycles = 0;
	localparam [55:0] IDS = {`IDX_MODE_CONTROL_TWO, `IDX_WAVEFORM_SOURCE_SELECT,
		`IDX_MEAS_IRQ_ENABLE_HIGH, `IDX_CURRENT_RMS_RESULT,
		`IDX_CURRENT_RMS_OFFSET, `IDX_VOLTAGE_RMS_RESULT,
		`IDX_VOLTAGE_RMS_OFFSET};

	// ==========================================================
	// Clock, units and watchdog
	always #5 mclk = ~mclk;

	rms_measurement_engine rms_measurement_engine_i (.mclk(mclk), .rst(rst),
		.ce(ce), .current_sample(current_sample),
		.voltage_sample(voltage_sample),
		.voltage_zero_cross(voltage_zero_cross), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wave_data_r(wave_data_r), .wave_strobe_r(wave_strobe_r));

	sample_source sample_source_i (.mclk(mclk), .rst(rst), .zx_req(zx_req),
		.cur_level(cur_level), .volt_level(volt_level),
		.current_sample(current_sample), .voltage_sample(voltage_sample),
		.voltage_zero_cross(voltage_zero_cross));

	// Cut a hang short well above the expected run length
	always @(posedge mclk)
	begin
		cycles = cycles + 1;
		if (cycles == 30000)
		begin
			errors = errors + 1;
			summarize;
		end
	end

	// ==========================================================
	// Shared tasks
	task summarize;
		begin
			if (errors == 0 && checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp)
			begin
				errors = errors + 1;
				$display("Error at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask

	// Idle edge first, so a release never meets the next setup
	task apb(input w, input [7:0] idx, input [31:0] d);
		begin
			@(posedge mclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= {2'b00, idx, 2'b00};
			pwdata <= d;
			@(posedge mclk);
			penable <= 1'b1;
			@(posedge mclk);
			// Only the watchdog ends a wait for ready
			while (pready !== 1'b1)
				@(posedge mclk);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task rdx(input [7:0] idx, input [31:0] exp);
		begin
			apb(1'b0, idx, 32'h00000000);
			chk(rd, exp);
		end
	endtask

	// Room for a tick and a root to land
	task setw(input [7:0] idx, input [31:0] d);
		begin
			apb(1'b1, idx, d);
			repeat (20) @(posedge mclk);
		end
	endtask

	// Cycles between two successive waveform strobes
	task gap(output integer n);
		integer k;
		begin
			k = 0;
			@(posedge mclk);
			while (wave_strobe_r !== 1'b1 && k < 3000)
			begin
				k = k + 1;
				@(posedge mclk);
			end
			@(posedge mclk);
			n = 1;
			while (wave_strobe_r !== 1'b1 && n < 3000)
			begin
				n = n + 1;
				@(posedge mclk);
			end
		end
	endtask

	// ==========================================================
	// Scenarios
	task t_reset_values;
		integer i;
		begin
			for (i = 0; i < 7; i = i + 1)
				rdx(IDS[i*8 +: 8], 32'h00000000);
		end
	endtask

	task t_access;
		begin
			apb(1'b1, `IDX_MODE_CONTROL_TWO, 32'hFFFFFFFF);
			rdx(`IDX_MODE_CONTROL_TWO, 32'h000000FF);
			apb(1'b1, `IDX_CURRENT_RMS_RESULT, 32'h00123456);
			chk({31'h00000000, er}, 32'h00000001);
			rdx(`IDX_CURRENT_RMS_RESULT, 32'h00000000);
			apb(1'b1, `IDX_VOLTAGE_RMS_RESULT, 32'h00123456);
			chk({31'h00000000, er}, 32'h00000001);
			apb(1'b0, 8'h10, 32'h00000000);
			chk({31'h00000000, er}, 32'h00000001);
			apb(1'b1, `IDX_MODE_CONTROL_TWO, 32'h00000000);
		end
	endtask

	// Quiet input, so the result is the offset term alone
	task t_volt_offset;
		begin
			setw(`IDX_VOLTAGE_RMS_OFFSET, 32'h00000005);
			rdx(`IDX_VOLTAGE_RMS_RESULT, 32'h00000140);
			rdx(`IDX_CURRENT_RMS_RESULT, 32'h00000000);
			setw(`IDX_VOLTAGE_RMS_OFFSET, 32'h000007FF);
			rdx(`IDX_VOLTAGE_RMS_RESULT, 32'h0001FFC0);
			setw(`IDX_VOLTAGE_RMS_OFFSET, 32'h00000FFB);
			rdx(`IDX_VOLTAGE_RMS_RESULT, 32'h00000000);
		end
	endtask

	task t_cur_offset;
		begin
			setw(`IDX_CURRENT_RMS_OFFSET, 32'h00000002);
			rdx(`IDX_CURRENT_RMS_RESULT, 32'h00000100);
			setw(`IDX_CURRENT_RMS_OFFSET, 32'h00000800);
			rdx(`IDX_CURRENT_RMS_RESULT, 32'h00000000);
			setw(`IDX_CURRENT_RMS_OFFSET, 32'h00000008);
			rdx(`IDX_CURRENT_RMS_RESULT, 32'h00000200);
			rdx(`IDX_VOLTAGE_RMS_RESULT, 32'h00000000);
		end
	endtask

	// Results must sit still until the voltage crosses
	task t_zero_cross;
		begin
			setw(`IDX_MODE_CONTROL_TWO, 32'h00000008);
			setw(`IDX_VOLTAGE_RMS_OFFSET, 32'h00000003);
			setw(`IDX_CURRENT_RMS_OFFSET, 32'h00000002);
			rdx(`IDX_VOLTAGE_RMS_RESULT, 32'h00000000);
			rdx(`IDX_CURRENT_RMS_RESULT, 32'h00000200);
			@(posedge mclk);
			zx_req <= 1'b1;
			@(posedge mclk);
			zx_req <= 1'b0;
			repeat (3) @(posedge mclk);
			rdx(`IDX_VOLTAGE_RMS_RESULT, 32'h000000C0);
			rdx(`IDX_CURRENT_RMS_RESULT, 32'h00000100);
			setw(`IDX_MODE_CONTROL_TWO, 32'h00000000);
		end
	endtask

	task t_wave;
		integer n;
		begin
			// Offset 8 alone gives a root of 0x200, scaled to 0x2C00
			setw(`IDX_CURRENT_RMS_OFFSET, 32'h00000008);
			setw(`IDX_MEAS_IRQ_ENABLE_HIGH, 32'h00000001);
			setw(`IDX_WAVEFORM_SOURCE_SELECT, 32'h00000005);
			gap(n);
			chk(n, 32'h000000A0);
			chk({8'h00, wave_data_r}, 32'h00002C00);
			setw(`IDX_WAVEFORM_SOURCE_SELECT, 32'h0000001D);
			gap(n);
			gap(n);
			chk(n, 32'h00000500);
			// Clock enable low must freeze the divider: no strobe at all
			ce <= 1'b0;
			n = 0;
			repeat (1500)
			begin
				@(posedge mclk);
				if (wave_strobe_r === 1'b1)
					n = n + 1;
			end
			ce <= 1'b1;
			chk(n, 32'h00000000);
			setw(`IDX_MEAS_IRQ_ENABLE_HIGH, 32'h00000000);
			n = 0;
			repeat (1500)
			begin
				@(posedge mclk);
				if (wave_strobe_r === 1'b1)
					n = n + 1;
			end
			chk(n, 32'h00000000);
		end
	endtask

	// Burst of 20 ticks of 2^40 on both channels: root near 0x4790,
	// far above the offset-only roots 0x200 and 0xC0; then a reset in mid-run
	task t_square;
		begin
			cur_level <= 24'h100000;
			volt_level <= 16'h1000;
			repeat (100) @(posedge mclk);
			cur_level <= 24'h000000;
			volt_level <= 16'h0000;
			repeat (20) @(posedge mclk);
			apb(1'b0, `IDX_CURRENT_RMS_RESULT, 32'h00000000);
			chk({31'h0, rd > 32'h4000 && rd < 32'h5000}, 32'h1);
			apb(1'b0, `IDX_VOLTAGE_RMS_RESULT, 32'h00000000);
			chk({31'h0, rd > 32'h4000 && rd < 32'h5000}, 32'h1);
			rst <= 1'b1;
			repeat (3) @(posedge mclk);
			rst <= 1'b0;
			rdx(`IDX_CURRENT_RMS_RESULT, 32'h00000000);
			rdx(`IDX_VOLTAGE_RMS_RESULT, 32'h00000000);
		end
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		t_reset_values;
		t_access;
		t_volt_offset;
		t_cur_offset;
		t_zero_cross;
		t_wave;
		t_square;
		summarize;
	end
endmodule // tb_top
